// >>> verilog/smis_params.svh
// smis_params.svh: offsets, bit positions and codes of the system-control
// masked interrupt block. assumes inclusion by bare name, definitions only.
`ifndef SMIS_PARAMS_SVH
`define SMIS_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define SMIS_ADDR_W 12
`define SMIS_OFS_PBOR 12'h030
`define SMIS_OFS_RAW 12'h050
`define SMIS_OFS_MASK 12'h054
`define SMIS_OFS_MISC 12'h058

// ----------------------------------------------------------------------
// source bit positions and widths
// ----------------------------------------------------------------------
`define SMIS_NSRC 7
`define SMIS_RSV_W 25
`define SMIS_SRC_PLL_LOCK 6
`define SMIS_SRC_CUR_LIM 5
`define SMIS_SRC_INT_OSC 4
`define SMIS_SRC_MAIN_OSC 3
`define SMIS_SRC_REG_UNREG 2
`define SMIS_SRC_BROWNOUT 1
`define SMIS_SRC_PLL_FAULT 0
`define SMIS_BOR_SEL_BIT 1
`define SMIS_LANE_LOW 0

// ----------------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------------
`define SMIS_SRC_RST 7'h00
`define SMIS_DATA_RST 32'h00000000
`define SMIS_RESP_OKAY 2'h0
`define SMIS_RESP_SLVERR 2'h2

`endif

// >>> verilog/smis_pkg.sv
// smis_pkg.sv: types of the system-control masked interrupt block.
// assumes smis_params.svh is on the include path.
`include "smis_params.svh"

package smis_pkg;

	typedef struct packed {
		logic [`SMIS_ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} smis_wreq_t;

	typedef enum logic [0:0] {
		SMIS_WR_IDLE = 1'b0,
		SMIS_WR_RESP = 1'b1
	} smis_wr_st_t;

	typedef enum logic [1:0] {
		SMIS_RD_IDLE = 2'b00,
		SMIS_RD_PEND = 2'b01,
		SMIS_RD_RESP = 2'b10
	} smis_rd_st_t;

endpackage : smis_pkg

// >>> verilog/smis_axil_slave.sv
// smis_axil_slave.sv: AXI4-Lite slave front end, one write and one read
// in flight. assumes the user side answers reads in the fire cycle.
`timescale 1ns/100ps
`include "smis_params.svh"

module smis_axil_slave import smis_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [`SMIS_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [`SMIS_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// user side
	output smis_wreq_t wr_req,
	output logic wr_fire,
	input wire logic wr_err,
	output logic [`SMIS_ADDR_W-1:0] rd_addr,
	output logic rd_fire,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	smis_wr_st_t wr_st_reg;
	smis_rd_st_t rd_st_reg;
	logic aw_held_reg;
	logic w_held_reg;

	// ------------------------------------------------------------------
	// write path
	// ------------------------------------------------------------------
	assign wr_fire = aw_held_reg && w_held_reg && wr_st_reg == SMIS_WR_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_held_reg <= 1'b0;
			wr_req.addr <= {`SMIS_ADDR_W{1'b0}};
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_held_reg <= 1'b1;
			wr_req.addr <= awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_held_reg <= 1'b0;
			wr_req.data <= `SMIS_DATA_RST;
			wr_req.strb <= 4'h0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_held_reg <= 1'b1;
			wr_req.data <= wdata;
			wr_req.strb <= wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_st_reg <= SMIS_WR_IDLE;
			bvalid <= 1'b0;
			bresp <= `SMIS_RESP_OKAY;
		end else if (wr_fire) begin
			wr_st_reg <= SMIS_WR_RESP;
			bvalid <= 1'b1;
			bresp <= wr_err ? `SMIS_RESP_SLVERR : `SMIS_RESP_OKAY;
		end else if (bvalid && bready) begin
			wr_st_reg <= SMIS_WR_IDLE;
			bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	assign rd_fire = rd_st_reg == SMIS_RD_PEND;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_st_reg <= SMIS_RD_IDLE;
			arready <= 1'b1;
			rd_addr <= {`SMIS_ADDR_W{1'b0}};
			rvalid <= 1'b0;
			rdata <= `SMIS_DATA_RST;
			rresp <= `SMIS_RESP_OKAY;
		end else begin
			unique case (rd_st_reg)
				SMIS_RD_IDLE: begin
					if (arvalid) begin
						arready <= 1'b0;
						rd_addr <= araddr;
						rd_st_reg <= SMIS_RD_PEND;
					end
				end
				SMIS_RD_PEND: begin
					rvalid <= 1'b1;
					rdata <= rd_data;
					rresp <= rd_err ? `SMIS_RESP_SLVERR : `SMIS_RESP_OKAY;
					rd_st_reg <= SMIS_RD_RESP;
				end
				SMIS_RD_RESP: begin
					if (rready) begin
						rvalid <= 1'b0;
						arready <= 1'b1;
						rd_st_reg <= SMIS_RD_IDLE;
					end
				end
				default: begin
					rd_st_reg <= SMIS_RD_IDLE;
				end
			endcase
		end
	end

endmodule : smis_axil_slave

// >>> verilog/smis_top.sv
// smis_top.sv: system-control raw status, mask and masked interrupt
// status/clear with one level interrupt. assumes event inputs are levels
// from detectors in other domains; registers reached over AXI4-Lite.
//
// Summary of operation
// R1 - masked bit is raw AND mask; drives interrupt
// R2 - writing 1 clears masked and raw bit
// R3 - bit 6 sets on PLL ready timer
// R4 - bit 5 sets on current-limit indication
// R5 - bit 4 sets on internal oscillator fault
// R6 - bit 3 sets on main oscillator fault
// R7 - bit 2 sets on unregulated regulator output
// R8 - brownout reported only if masked, interrupt selected
// R9 - bit 0 sets when PLL stops oscillating
// R10 - bits 31 to 7 reserved, read-only
// R11 - mask bits in separate register, same positions
// R12 - writing 0 keeps bits; interrupt while any set
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "smis_params.svh"

module smis_top import smis_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [`SMIS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [`SMIS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// event levels from detectors
	input wire logic pll_ready_evt,
	input wire logic current_limit_evt,
	input wire logic int_osc_fault_evt,
	input wire logic main_osc_fault_evt,
	input wire logic regulator_unreg_evt,
	input wire logic brownout_evt,
	input wire logic pll_fault_evt,
	// interrupt to processor
	output logic irq
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	smis_wreq_t wr_req;
	logic wr_fire;
	logic wr_err;
	logic [`SMIS_ADDR_W-1:0] rd_addr;
	logic rd_fire;
	logic [31:0] rd_data;
	logic rd_err;

	logic [`SMIS_NSRC-1:0] evt_in;
	logic [`SMIS_NSRC-1:0] evt_s1_reg;
	logic [`SMIS_NSRC-1:0] evt_s2_reg;
	logic [`SMIS_NSRC-1:0] evt_prev_reg;
	logic [`SMIS_NSRC-1:0] set_vec;

	logic [`SMIS_NSRC-1:0] raw_status_reg;
	logic [`SMIS_NSRC-1:0] raw_status_next;
	logic [`SMIS_NSRC-1:0] irq_mask_reg;
	logic [`SMIS_NSRC-1:0] irq_mask_next;
	logic brownout_reset_select_reg;
	logic brownout_reset_select_next;
	logic irq_reg;

	logic [`SMIS_NSRC-1:0] w1c_clr;
	logic [`SMIS_NSRC-1:0] rd_clr;
	logic [`SMIS_NSRC-1:0] bor_gate;
	logic [`SMIS_NSRC-1:0] bor_gate_next;
	logic [`SMIS_NSRC-1:0] masked_vec;

	logic wr_hit_raw;
	logic wr_hit_mask;
	logic wr_hit_misc;
	logic wr_hit_pbor;
	logic wr_lane0;
	logic rd_hit_raw;

	logic pll_lock_masked_flag;
	logic current_limit_masked_flag;
	logic int_osc_fault_masked_flag;
	logic main_osc_fault_masked_flag;
	logic regulator_unreg_masked_flag;
	logic brownout_masked_flag;
	logic pll_fault_masked_flag;

	// ------------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------------
	smis_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_req(wr_req),
		.wr_fire(wr_fire),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_fire(rd_fire),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// ------------------------------------------------------------------
	// event capture: two-flop sync then rising edge
	// ------------------------------------------------------------------
	assign evt_in[`SMIS_SRC_PLL_LOCK] = pll_ready_evt;
	assign evt_in[`SMIS_SRC_CUR_LIM] = current_limit_evt;
	assign evt_in[`SMIS_SRC_INT_OSC] = int_osc_fault_evt;
	assign evt_in[`SMIS_SRC_MAIN_OSC] = main_osc_fault_evt;
	assign evt_in[`SMIS_SRC_REG_UNREG] = regulator_unreg_evt;
	assign evt_in[`SMIS_SRC_BROWNOUT] = brownout_evt;
	assign evt_in[`SMIS_SRC_PLL_FAULT] = pll_fault_evt;

	genvar gi;
	generate
		for (gi = 0; gi < `SMIS_NSRC; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					evt_s1_reg[gi] <= 1'b0;
					evt_s2_reg[gi] <= 1'b0;
					evt_prev_reg[gi] <= 1'b0;
				end else begin
					evt_s1_reg[gi] <= evt_in[gi];
					evt_s2_reg[gi] <= evt_s1_reg[gi];
					evt_prev_reg[gi] <= evt_s2_reg[gi];
				end
			end
			assign set_vec[gi] = evt_s2_reg[gi] && !evt_prev_reg[gi];
		end
	endgenerate

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	assign wr_lane0 = wr_req.strb[`SMIS_LANE_LOW];
	assign wr_hit_raw = wr_fire && {wr_req.addr[11:2], 2'b00} == `SMIS_OFS_RAW;
	assign wr_hit_mask = wr_fire
		&& {wr_req.addr[11:2], 2'b00} == `SMIS_OFS_MASK;
	assign wr_hit_misc = wr_fire
		&& {wr_req.addr[11:2], 2'b00} == `SMIS_OFS_MISC;
	assign wr_hit_pbor = wr_fire
		&& {wr_req.addr[11:2], 2'b00} == `SMIS_OFS_PBOR;
	assign wr_err = wr_fire && !(wr_hit_raw || wr_hit_mask || wr_hit_misc
		|| wr_hit_pbor);
	assign rd_hit_raw = rd_fire && {rd_addr[11:2], 2'b00} == `SMIS_OFS_RAW;

	// ------------------------------------------------------------------
	// next-state: set wins over clear
	// ------------------------------------------------------------------
	always_comb begin
		w1c_clr = `SMIS_SRC_RST;
		if (wr_hit_misc && wr_lane0) begin
			w1c_clr = wr_req.data[`SMIS_NSRC-1:0]; // R2
		end
		rd_clr = rd_hit_raw ? raw_status_reg : `SMIS_SRC_RST;
		raw_status_next = (raw_status_reg & ~(w1c_clr | rd_clr)) | set_vec; // R12
		irq_mask_next = irq_mask_reg;
		if (wr_hit_mask && wr_lane0) begin
			irq_mask_next = wr_req.data[`SMIS_NSRC-1:0]; // R11
		end
		brownout_reset_select_next = brownout_reset_select_reg;
		if (wr_hit_pbor && wr_lane0) begin
			brownout_reset_select_next = wr_req.data[`SMIS_BOR_SEL_BIT];
		end
		bor_gate = {`SMIS_NSRC{1'b1}};
		bor_gate[`SMIS_SRC_BROWNOUT] = !brownout_reset_select_reg; // R8
		bor_gate_next = {`SMIS_NSRC{1'b1}};
		bor_gate_next[`SMIS_SRC_BROWNOUT] = !brownout_reset_select_next;
	end

	// ------------------------------------------------------------------
	// status, mask and control registers
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_status_reg <= `SMIS_SRC_RST;
		end else begin
			raw_status_reg <= raw_status_next; // R3 R4 R5 R6 R7 R9
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= `SMIS_SRC_RST;
		end else begin
			irq_mask_reg <= irq_mask_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brownout_reset_select_reg <= 1'b0;
		end else begin
			brownout_reset_select_reg <= brownout_reset_select_next;
		end
	end

	// tracks the masked view so irq follows it with no lag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(raw_status_next & irq_mask_next & bor_gate_next); // R1
		end
	end
	assign irq = irq_reg;

	// ------------------------------------------------------------------
	// masked view and read mux
	// ------------------------------------------------------------------
	assign masked_vec = raw_status_reg & irq_mask_reg & bor_gate; // R1
	assign pll_lock_masked_flag = masked_vec[`SMIS_SRC_PLL_LOCK];
	assign current_limit_masked_flag = masked_vec[`SMIS_SRC_CUR_LIM];
	assign int_osc_fault_masked_flag = masked_vec[`SMIS_SRC_INT_OSC];
	assign main_osc_fault_masked_flag = masked_vec[`SMIS_SRC_MAIN_OSC];
	assign regulator_unreg_masked_flag = masked_vec[`SMIS_SRC_REG_UNREG];
	assign brownout_masked_flag = masked_vec[`SMIS_SRC_BROWNOUT];
	assign pll_fault_masked_flag = masked_vec[`SMIS_SRC_PLL_FAULT];

	always_comb begin
		rd_data = `SMIS_DATA_RST;
		rd_err = 1'b0;
		unique case ({rd_addr[11:2], 2'b00})
			`SMIS_OFS_RAW: rd_data = {{`SMIS_RSV_W{1'b0}}, raw_status_reg};
			`SMIS_OFS_MASK: rd_data = {{`SMIS_RSV_W{1'b0}}, irq_mask_reg};
			`SMIS_OFS_MISC: begin
				rd_data = {{`SMIS_RSV_W{1'b0}}, pll_lock_masked_flag, // R10
					current_limit_masked_flag, int_osc_fault_masked_flag,
					main_osc_fault_masked_flag, regulator_unreg_masked_flag,
					brownout_masked_flag, pll_fault_masked_flag};
			end
			`SMIS_OFS_PBOR: begin
				rd_data[`SMIS_BOR_SEL_BIT] = brownout_reset_select_reg;
			end
			default: rd_err = rd_fire;
		endcase
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	AST_IRQ_MATCHES_MASKED: assert property (@(posedge aclk) // R1
		disable iff (!aresetn)
		irq == (|masked_vec))
		else $error("irq differs from masked status");

	AST_W1C_CLEARS_RAW: assert property (@(posedge aclk) // R2
		disable iff (!aresetn)
		(wr_hit_misc && wr_lane0) |=>
		((raw_status_reg & $past(w1c_clr & ~set_vec)) == `SMIS_SRC_RST))
		else $error("write one did not clear status bit");

	AST_ZERO_KEEPS_BITS: assert property (@(posedge aclk) // R12
		disable iff (!aresetn)
		##1 ((raw_status_reg & $past(raw_status_reg & ~(w1c_clr | rd_clr)))
		== $past(raw_status_reg & ~(w1c_clr | rd_clr))))
		else $error("status bit lost without a clear");

	AST_PLL_LOCK_SET: assert property (@(posedge aclk) // R3
		disable iff (!aresetn)
		(set_vec[`SMIS_SRC_PLL_LOCK] && irq_mask_next[`SMIS_SRC_PLL_LOCK])
		|=> pll_lock_masked_flag && irq)
		else $error("pll lock event not flagged");

	AST_CUR_LIM_SET: assert property (@(posedge aclk) // R4
		disable iff (!aresetn)
		$rose(evt_s2_reg[`SMIS_SRC_CUR_LIM])
		|-> ##1 raw_status_reg[`SMIS_SRC_CUR_LIM])
		else $error("current limit event not captured");

	AST_INT_OSC_SET: assert property (@(posedge aclk) // R5
		disable iff (!aresetn)
		set_vec[`SMIS_SRC_INT_OSC] |=> (int_osc_fault_masked_flag
		== irq_mask_reg[`SMIS_SRC_INT_OSC]))
		else $error("internal oscillator fault not flagged");

	AST_MAIN_OSC_SET: assert property (@(posedge aclk) // R6
		disable iff (!aresetn)
		set_vec[`SMIS_SRC_MAIN_OSC] |=> raw_status_reg[`SMIS_SRC_MAIN_OSC])
		else $error("main oscillator fault not captured");

	AST_REG_UNREG_SET: assert property (@(posedge aclk) // R7
		disable iff (!aresetn)
		(set_vec[`SMIS_SRC_REG_UNREG] && irq_mask_next[`SMIS_SRC_REG_UNREG])
		|=> regulator_unreg_masked_flag && irq)
		else $error("regulator fault not flagged");

	AST_BROWNOUT_GATE: assert property (@(posedge aclk) // R8
		disable iff (!aresetn)
		brownout_masked_flag == (raw_status_reg[`SMIS_SRC_BROWNOUT]
		&& irq_mask_reg[`SMIS_SRC_BROWNOUT] && !brownout_reset_select_reg))
		else $error("brownout reported against its gating");

	AST_PLL_FAULT_SET: assert property (@(posedge aclk) // R9
		disable iff (!aresetn)
		set_vec[`SMIS_SRC_PLL_FAULT] |=> raw_status_reg[`SMIS_SRC_PLL_FAULT])
		else $error("pll fault not captured");

	AST_RESERVED_ZERO: assert property (@(posedge aclk) // R10
		disable iff (!aresetn)
		rd_fire |-> (rd_data[31:`SMIS_NSRC] == `SMIS_RSV_W'h0000000))
		else $error("reserved read bits not zero");

	AST_MASK_WRITE: assert property (@(posedge aclk) // R11
		disable iff (!aresetn)
		(wr_hit_mask && wr_lane0) |=>
		(irq_mask_reg == $past(wr_req.data[`SMIS_NSRC-1:0])))
		else $error("mask register did not take write");

endmodule : smis_top

// >>> verif/smis_irq_model.sv
// smis_irq_model.sv: behavioural interrupt input of the processor side.
// assumes irq is a level from the block, synchronous to aclk.
`timescale 1ns/100ps

module smis_irq_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// interrupt level and rise tally
	input wire logic irq,
	output int rise_cnt
);
	logic irq_q;

	// ----------------------------------------------------------------
	// count each new request seen by the controller
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
			rise_cnt <= 0;
		end else begin
			irq_q <= irq;
			if (irq && !irq_q) begin
				rise_cnt <= rise_cnt + 1;
			end
		end
	end
endmodule : smis_irq_model

// >>> verif/test_sysctl_masked_irq_status.sv
// test_sysctl_masked_irq_status.sv: self-checking bench of smis_top.
// assumes smis_params.svh on the include path, smis_irq_model compiled.
`timescale 1ns/100ps
`include "smis_params.svh"

module test_sysctl_masked_irq_status import smis_pkg::*;;
	logic aclk, aresetn;
	logic [`SMIS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq;
	logic [6:0] evt;
	int fails, cmp_count, cyc, rises, raw_m, mask_m, sel_m, e;

	smis_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pll_ready_evt(evt[6]), .current_limit_evt(evt[5]),
		.int_osc_fault_evt(evt[4]), .main_osc_fault_evt(evt[3]),
		.regulator_unreg_evt(evt[2]), .brownout_evt(evt[1]),
		.pll_fault_evt(evt[0]), .irq);
	smis_irq_model irq_u (.aclk, .aresetn, .irq, .rise_cnt(rises));

	always #4 aclk = ~aclk;

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, x, g);
		end
	endtask : chk

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// model and bus tasks
	// ----------------------------------------------------------------
	function automatic int msk_f();
		return raw_m & mask_m & ~(sel_m << 1) & 'h7F;
	endfunction : msk_f

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (!aw_d && s_axi_awready === 1'b1) begin
				aw_d = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready === 1'b1) begin
				w_d = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			fails++;
			complete_run();
		end
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			fails++;
			complete_run();
		end
		chk($sformatf("reg %h", a), x, rd);
		if (a == `SMIS_OFS_RAW) begin
			raw_m = 0;
		end
	endtask : rd_chk

	// one rising edge on the chosen event inputs, then settle
	task automatic fire(input logic [6:0] m);
		@(posedge aclk);
		evt <= m;
		repeat (2) @(posedge aclk);
		evt <= 7'h00;
		repeat (4) @(posedge aclk);
		raw_m = raw_m | m;
	endtask : fire

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 0;
		aresetn = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		evt = 7'h00;
		{fails, cmp_count, cyc, raw_m, mask_m, sel_m} = '0;
		void'($urandom(6438));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(`SMIS_OFS_RAW, 32'h0);
		rd_chk(`SMIS_OFS_MASK, 32'h0);
		rd_chk(`SMIS_OFS_MISC, 32'h0);
		rd_chk(12'h100, 32'h0);
		chk("rresp", `SMIS_RESP_SLVERR, rsp);
		wr(12'h104, 32'hFFFFFFFF);
		chk("bresp", `SMIS_RESP_SLVERR, rsp);
		wr(`SMIS_OFS_MASK, 32'hFFFFFFFF);
		mask_m = 'h7F;
		rd_chk(`SMIS_OFS_MASK, 32'h7F);
		chk("rresp", `SMIS_RESP_OKAY, rsp);
		for (int i = 0; i < 7; i++) begin
			fire(7'(1 << i));
			rd_chk(`SMIS_OFS_MISC, msk_f());
			chk("irq", 32'h1, {31'h0, irq});
			wr(`SMIS_OFS_MISC, 32'h0);
			rd_chk(`SMIS_OFS_MISC, msk_f());
			wr(`SMIS_OFS_MISC, 32'(1 << i));
			raw_m = raw_m & ~(1 << i);
			rd_chk(`SMIS_OFS_MISC, 32'h0);
			chk("irq", 32'h0, {31'h0, irq});
			rd_chk(`SMIS_OFS_RAW, 32'h0);
		end
		chk("rises", 32'h7, rises);
		wr(`SMIS_OFS_PBOR, 32'h2);
		sel_m = 1;
		fire(7'h02);
		rd_chk(`SMIS_OFS_MISC, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`SMIS_OFS_PBOR, 32'h0);
		sel_m = 0;
		rd_chk(`SMIS_OFS_MISC, 32'h2);
		wr(`SMIS_OFS_MISC, 32'h2);
		raw_m = 0;
		wr(`SMIS_OFS_MASK, 32'h0);
		mask_m = 0;
		fire(7'h7F);
		rd_chk(`SMIS_OFS_MISC, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`SMIS_OFS_RAW, 32'h7F);
		chk("bresp", `SMIS_RESP_OKAY, rsp);
		rd_chk(`SMIS_OFS_RAW, 32'h7F);
		for (int k = 0; k < 20; k++) begin
			mask_m = $urandom & 'h7F;
			sel_m = $urandom & 1;
			e = $urandom & 'h7F;
			wr(`SMIS_OFS_MASK, 32'(mask_m));
			wr(`SMIS_OFS_PBOR, 32'(sel_m << 1));
			fire(7'(e));
			e = msk_f();
			rd_chk(`SMIS_OFS_MISC, 32'(e));
			chk("irq", 32'(e != 0), {31'h0, irq});
			wr(`SMIS_OFS_MISC, 32'(e));
			raw_m = raw_m & ~e;
			rd_chk(`SMIS_OFS_RAW, 32'(raw_m));
		end
		complete_run();
	end
endmodule : test_sysctl_masked_irq_status
